// file: cac_pkg.sv
// Function
// - The alarm value is compared against the calendar value at every counter step, using only the fields the match select enables.
// - A match sets the alarm flag at the following counter step, never in the step of the match itself.
// - On a match the calendar is cleared when match clear is one, and keeps counting otherwise.
// - The year field (bits 31:26) takes part only when the match select equals 6.
// - The month field (bits 25:22) takes part only when the match select is above 4.
// - The day field (bits 21:17) takes part only when the match select is above 3.
// - The hour field (bits 16:12) takes part only when the match select is above 2.
// - The minute field (bits 11:6) takes part only when the match select is above 1.
// - The second field (bits 5:0) takes part only when the match select is above 0.
// - Calendar counting and alarm matching work only while the mode field holds 2.
// - Registers take 8-, 16- and 32-bit accesses, including single bytes and halves of wider registers.
// - Alarm writes pass a synchronisation delay and are refused while the write guard is active.
package cac_pkg;

	localparam int ADDR_W = 8;
	localparam int PRESC_W = 24;
	localparam int CLK_HZ = 10000000;
	localparam int COUNT_HZ = 1;
	localparam int TICK_CYCLES_DEF = CLK_HZ / COUNT_HZ;
	localparam logic [1:0] SYNC_CYCLES = 2'h2;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CONTROL_A = 6'h00;
	localparam logic [5:0] IDX_EVENT_CTRL = 6'h04;
	localparam logic [5:0] IDX_INTEN_CLR = 6'h08;
	localparam logic [5:0] IDX_INTEN_SET = 6'h0a;
	localparam logic [5:0] IDX_FLAGS = 6'h0c;
	localparam logic [5:0] IDX_DEBUG = 6'h0e;
	localparam logic [5:0] IDX_SYNC = 6'h10;
	localparam logic [5:0] IDX_FREQ = 6'h14;
	localparam logic [5:0] IDX_CALENDAR = 6'h18;
	localparam logic [5:0] IDX_ALARM = 6'h20;
	localparam logic [5:0] IDX_FIELD_SEL = 6'h24;

	localparam int CTL_SWRST = 0;
	localparam int CTL_ENABLE = 1;
	localparam int CTL_MODE_LO = 2;
	localparam int CTL_MATCH_CLEAR = 7;
	localparam logic [1:0] MODE_CALENDAR = 2'h2;
	localparam int FLG_ALARM = 8;
	localparam int FLG_OVF = 15;
	localparam int SB_ALARM = 5;

	localparam logic [31:0] MASK_CTRL = 32'h0000_8fcf;
	localparam logic [31:0] MASK_EVENT = 32'h0000_81ff;
	localparam logic [31:0] MASK_INT = 32'h0000_8100;
	localparam logic [31:0] MASK_DEBUG = 32'h0000_0001;
	localparam logic [31:0] MASK_FREQ = 32'h0000_00ff;
	localparam logic [31:0] MASK_SEL = 32'h0000_0007;

	localparam logic [5:0] SEC_MAX = 6'h3b;
	localparam logic [5:0] MIN_MAX = 6'h3b;
	localparam logic [4:0] HOUR_MAX = 5'h17;
	localparam logic [4:0] DAY_MAX = 5'h1f;
	localparam logic [3:0] MONTH_MAX = 4'hc;
	localparam logic [5:0] YEAR_MAX = 6'h3f;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} cac_axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} cac_axil_rsp_s;

	typedef struct packed {
		cac_axil_rsp_s bus;
		logic [15:0] ctrl;
		logic [31:0] event_ctrl;
		logic [15:0] inten;
		logic [15:0] flags;
		logic [7:0] dbg;
		logic [7:0] freq;
		logic [31:0] cal;
		logic [31:0] alarm;
		logic [31:0] alarm_shadow;
		logic [1:0] sync_cnt;
		logic [2:0] sel;
		logic match_pend;
		logic [PRESC_W-1:0] presc;
		logic alarm_event;
		logic ovf_event;
	} cac_state_s;

	// Every documented reset value of this block is zero
	localparam cac_state_s CAC_STATE_RESET = '0;

endpackage

// file: cac_calendar_alarm.sv
// Calendar counter with alarm compare and AXI4-Lite register slave
`timescale 1ns/100ps
module cac_calendar_alarm import cac_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire cac_axil_req_s axil_req,
	output cac_axil_rsp_s axil_rsp,
	input wire logic peripheral_write_guard,
	output logic alarm_event,
	output logic overflow_event
);

	cac_state_s state_reg;
	cac_state_s state_next;
	logic run;
	logic tick;
	logic do_write;
	logic do_read;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic swrst_req_seen;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res & mask;
	endfunction

	function automatic logic fmatch(input logic [31:0] a, input logic [31:0] c, input logic [2:0] sel);
		logic m;
		m = 1'b1;
		if (sel == 3'h6 && a[31:26] != c[31:26]) m = 1'b0;
		if (sel > 3'h4 && a[25:22] != c[25:22]) m = 1'b0;
		if (sel > 3'h3 && a[21:17] != c[21:17]) m = 1'b0;
		if (sel > 3'h2 && a[16:12] != c[16:12]) m = 1'b0;
		if (sel > 3'h1 && a[11:6] != c[11:6]) m = 1'b0;
		if (sel > 3'h0 && a[5:0] != c[5:0]) m = 1'b0;
		return m;
	endfunction

	// Returns the overflow bit above the advanced calendar value
	function automatic logic [32:0] cal_inc(input logic [31:0] c);
		logic [5:0] se;
		logic [5:0] mi;
		logic [4:0] hr;
		logic [4:0] dy;
		logic [3:0] mo;
		logic [5:0] yr;
		logic ov;
		se = c[5:0];
		mi = c[11:6];
		hr = c[16:12];
		dy = c[21:17];
		mo = c[25:22];
		yr = c[31:26];
		ov = 1'b0;
		if (se != SEC_MAX) begin
			se = se + 6'h01;
		end else begin
			se = 6'h00;
			if (mi != MIN_MAX) begin
				mi = mi + 6'h01;
			end else begin
				mi = 6'h00;
				if (hr != HOUR_MAX) begin
					hr = hr + 5'h01;
				end else begin
					hr = 5'h00;
					// Month lengths are not modelled; every month runs to the top day
					if (dy < DAY_MAX) begin
						dy = dy + 5'h01;
					end else begin
						dy = 5'h01;
						if (mo < MONTH_MAX) begin
							mo = mo + 4'h1;
						end else begin
							mo = 4'h1;
							if (yr != YEAR_MAX) begin
								yr = yr + 6'h01;
							end else begin
								yr = 6'h00;
								ov = 1'b1;
							end
						end
					end
				end
			end
		end
		return {ov, yr, mo, dy, hr, mi, se};
	endfunction

	function automatic logic [32:0] reg_read(input cac_state_s s, input logic [5:0] idx);
		logic [32:0] r;
		r = {1'b0, 32'h0000_0000};
		unique case (idx)
			IDX_CONTROL_A: r[31:0] = {16'h0000, s.ctrl};
			IDX_EVENT_CTRL: r[31:0] = s.event_ctrl;
			IDX_INTEN_CLR: r[31:0] = {16'h0000, s.inten};
			IDX_INTEN_SET: r[31:0] = {16'h0000, s.inten};
			IDX_FLAGS: r[31:0] = {16'h0000, s.flags};
			IDX_DEBUG: r[31:0] = {24'h000000, s.dbg};
			IDX_SYNC: r[SB_ALARM] = (s.sync_cnt != 2'h0);
			IDX_FREQ: r[31:0] = {24'h000000, s.freq};
			IDX_CALENDAR: r[31:0] = s.cal;
			IDX_ALARM: r[31:0] = s.alarm;
			IDX_FIELD_SEL: r[31:0] = {29'h0000_0000, s.sel};
			default: r[32] = 1'b1;
		endcase
		return r;
	endfunction

	assign run = state_reg.ctrl[CTL_ENABLE] && (state_reg.ctrl[CTL_MODE_LO +: 2] == MODE_CALENDAR);
	assign tick = run && (state_reg.presc == PRESC_W'(TICK_CYCLES - 1));
	assign do_write = state_reg.bus.awready;
	assign do_read = state_reg.bus.arready;
	assign wr_idx = axil_req.awaddr[ADDR_W-1:2];
	assign rd_idx = axil_req.araddr[ADDR_W-1:2];
	assign swrst_req_seen = do_write && !peripheral_write_guard && wr_idx == IDX_CONTROL_A &&
		axil_req.wstrb[0] && axil_req.wdata[CTL_SWRST];

	always_comb begin
		logic [32:0] inc;
		logic [32:0] rd;
		logic [15:0] set_bits;
		logic swrst_req;
		cac_axil_rsp_s keep_bus;
		inc = cal_inc(state_reg.cal);
		rd = reg_read(state_reg, rd_idx);
		set_bits = 16'h0000;
		swrst_req = 1'b0;
		keep_bus = '0;
		state_next = state_reg;
		state_next.alarm_event = 1'b0;
		state_next.ovf_event = 1'b0;

		// Prescaler gives one counter step per TICK_CYCLES clocks
		// A stopped counter drops its captured match, so a restart cannot fire a stale alarm
		if (!run) begin
			state_next.presc = '0;
			state_next.match_pend = 1'b0;
		end else if (tick) begin
			state_next.presc = '0;
		end else begin
			state_next.presc = state_reg.presc + PRESC_W'(1);
		end

		if (tick) begin
			state_next.match_pend = fmatch(state_reg.alarm, state_reg.cal, state_reg.sel);
			if (state_reg.match_pend) begin
				set_bits[FLG_ALARM] = 1'b1;
				state_next.alarm_event = state_reg.event_ctrl[FLG_ALARM];
			end
			if (state_reg.match_pend && state_reg.ctrl[CTL_MATCH_CLEAR]) begin
				state_next.cal = 32'h0000_0000;
			end else begin
				state_next.cal = inc[31:0];
				set_bits[FLG_OVF] = inc[32];
				state_next.ovf_event = inc[32] && state_reg.event_ctrl[FLG_OVF];
			end
		end

		// Alarm writes land only after the synchronisation delay
		if (state_reg.sync_cnt != 2'h0) begin
			state_next.sync_cnt = state_reg.sync_cnt - 2'h1;
			if (state_reg.sync_cnt == 2'h1) begin
				state_next.alarm = state_reg.alarm_shadow;
			end
		end

		// Write channel: address and data are taken together
		if (do_write) begin
			state_next.bus.awready = 1'b0;
			state_next.bus.wready = 1'b0;
			state_next.bus.bvalid = 1'b1;
			state_next.bus.bresp = RESP_OKAY;
			if (peripheral_write_guard) begin
				state_next.bus.bresp = RESP_SLVERR;
			end else begin
				unique case (wr_idx)
					IDX_CONTROL_A: begin
						state_next.ctrl = 16'(wmerge({16'h0000, state_reg.ctrl}, axil_req.wdata, axil_req.wstrb,
							MASK_CTRL));
						swrst_req = axil_req.wstrb[0] && axil_req.wdata[CTL_SWRST];
					end
					IDX_EVENT_CTRL: state_next.event_ctrl = wmerge(state_reg.event_ctrl, axil_req.wdata,
						axil_req.wstrb, MASK_EVENT);
					IDX_INTEN_CLR: state_next.inten = state_reg.inten &
						~16'(wmerge(32'h0000_0000, axil_req.wdata, axil_req.wstrb, MASK_INT));
					IDX_INTEN_SET: state_next.inten = state_reg.inten |
						16'(wmerge(32'h0000_0000, axil_req.wdata, axil_req.wstrb, MASK_INT));
					IDX_FLAGS: state_next.flags = state_reg.flags &
						~16'(wmerge(32'h0000_0000, axil_req.wdata, axil_req.wstrb, MASK_INT));
					IDX_DEBUG: state_next.dbg = 8'(wmerge({24'h000000, state_reg.dbg}, axil_req.wdata, axil_req.wstrb,
						MASK_DEBUG));
					IDX_SYNC: state_next.bus.bresp = RESP_OKAY;
					IDX_FREQ: state_next.freq = 8'(wmerge({24'h000000, state_reg.freq}, axil_req.wdata, axil_req.wstrb,
						MASK_FREQ));
					IDX_CALENDAR: state_next.cal = wmerge(state_reg.cal, axil_req.wdata, axil_req.wstrb, 32'hffff_ffff);
					IDX_ALARM: begin
						// A second write restarts the delay and merges over the pending value
						state_next.alarm_shadow = wmerge((state_reg.sync_cnt != 2'h0) ? state_reg.alarm_shadow :
							state_reg.alarm, axil_req.wdata, axil_req.wstrb, 32'hffff_ffff);
						state_next.sync_cnt = SYNC_CYCLES;
					end
					IDX_FIELD_SEL: state_next.sel = 3'(wmerge({29'h0000_0000, state_reg.sel}, axil_req.wdata,
						axil_req.wstrb, MASK_SEL));
					default: state_next.bus.bresp = RESP_SLVERR;
				endcase
			end
		end else if (!state_reg.bus.bvalid && axil_req.awvalid && axil_req.wvalid) begin
			state_next.bus.awready = 1'b1;
			state_next.bus.wready = 1'b1;
		end
		if (state_reg.bus.bvalid && axil_req.bready) begin
			state_next.bus.bvalid = 1'b0;
		end

		if (do_read) begin
			state_next.bus.arready = 1'b0;
			state_next.bus.rvalid = 1'b1;
			state_next.bus.rdata = rd[31:0];
			state_next.bus.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
		end else if (!state_reg.bus.rvalid && axil_req.arvalid) begin
			state_next.bus.arready = 1'b1;
		end
		if (state_reg.bus.rvalid && axil_req.rready) begin
			state_next.bus.rvalid = 1'b0;
		end

		// Hardware set beats a software clear in the same cycle
		state_next.flags = state_next.flags | set_bits;

		// Software reset spares the bus so the pending answer still completes
		if (swrst_req) begin
			keep_bus = state_next.bus;
			state_next = CAC_STATE_RESET;
			state_next.bus = keep_bus;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= CAC_STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign axil_rsp = state_reg.bus;
	assign alarm_event = state_reg.alarm_event;
	assign overflow_event = state_reg.ovf_event;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_match_step;
		tick && state_reg.match_pend;
	endsequence

	sequence s_alarm_write;
		do_write && !peripheral_write_guard && wr_idx == IDX_ALARM;
	endsequence

	a_compare_fields: assert property (tick |=> state_reg.match_pend ==
		fmatch($past(state_reg.alarm), $past(state_reg.cal), $past(state_reg.sel)))
		else $error("match pending does not follow compare");
	a_flag_next_step: assert property (s_match_step |=> state_reg.flags[FLG_ALARM] || $past(swrst_req_seen))
		else $error("alarm flag not set after match");
	a_flag_not_early: assert property ($rose(state_reg.flags[FLG_ALARM]) |-> $past(state_reg.match_pend && tick))
		else $error("alarm flag set without prior match");
	a_clear_on_match: assert property (s_match_step ##0 state_reg.ctrl[CTL_MATCH_CLEAR] && !do_write
		|=> state_reg.cal == 32'h0000_0000)
		else $error("calendar not cleared on match");
	a_run_on_match: assert property (s_match_step ##0 !state_reg.ctrl[CTL_MATCH_CLEAR] && !do_write
		|=> state_reg.cal != 32'h0000_0000)
		else $error("calendar cleared without match clear");
	a_year_mask: assert property (state_reg.sel != 3'h6 |->
		fmatch(state_reg.alarm, state_reg.cal ^ 32'hfc00_0000, state_reg.sel) ==
		fmatch(state_reg.alarm, state_reg.cal, state_reg.sel))
		else $error("year compared outside select 6");
	a_month_mask: assert property (state_reg.sel > 3'h4 && state_reg.alarm[25:22] != state_reg.cal[25:22]
		|-> !fmatch(state_reg.alarm, state_reg.cal, state_reg.sel))
		else $error("month ignored above select 4");
	a_day_mask: assert property (state_reg.sel <= 3'h3 |->
		fmatch(state_reg.alarm, state_reg.cal ^ 32'h003e_0000, state_reg.sel) ==
		fmatch(state_reg.alarm, state_reg.cal, state_reg.sel))
		else $error("day compared at select 3 or below");
	a_hour_mask: assert property (state_reg.sel > 3'h2 && state_reg.alarm[16:12] != state_reg.cal[16:12]
		|-> !fmatch(state_reg.alarm, state_reg.cal, state_reg.sel))
		else $error("hour ignored above select 2");
	a_minute_mask: assert property (state_reg.sel <= 3'h1 |->
		fmatch(state_reg.alarm, state_reg.cal ^ 32'h0000_0fc0, state_reg.sel) ==
		fmatch(state_reg.alarm, state_reg.cal, state_reg.sel))
		else $error("minute compared at select 1 or below");
	a_second_mask: assert property (state_reg.sel == 3'h0 |-> fmatch(state_reg.alarm, state_reg.cal, state_reg.sel))
		else $error("select 0 must always match");
	a_mode_gate: assert property (state_reg.ctrl[CTL_MODE_LO +: 2] != MODE_CALENDAR && !do_write
		|=> $stable(state_reg.cal))
		else $error("calendar moved outside calendar mode");
	a_byte_lanes: assert property (do_write && !peripheral_write_guard && wr_idx == IDX_FREQ &&
		!axil_req.wstrb[0] |=> $stable(state_reg.freq))
		else $error("disabled byte lane was written");
	a_alarm_sync: assert property (s_alarm_write |=> state_reg.sync_cnt == SYNC_CYCLES ##2
		state_reg.alarm == $past(state_reg.alarm_shadow) || state_reg.sync_cnt != 2'h0)
		else $error("alarm write not applied after delay");
	a_guard_blocks: assert property (do_write && peripheral_write_guard |=>
		$stable(state_reg.alarm_shadow) && state_reg.bus.bresp == RESP_SLVERR && state_reg.bus.bvalid)
		else $error("guarded write not refused");
	a_flag_clear: assert property (do_write && !peripheral_write_guard && wr_idx == IDX_FLAGS &&
		axil_req.wstrb[1] && axil_req.wdata[FLG_ALARM] && !(tick && state_reg.match_pend)
		|=> !state_reg.flags[FLG_ALARM])
		else $error("alarm flag not cleared by one");
	a_match_stop: assert property (!run |=> !state_reg.match_pend)
		else $error("stale match kept while stopped");
	a_event_pulse: assert property (s_match_step ##0 state_reg.event_ctrl[FLG_ALARM] && !swrst_req_seen
		|=> alarm_event)
		else $error("alarm event missing after match");
	a_month_low: assert property (state_reg.sel <= 3'h4 |->
		fmatch(state_reg.alarm, state_reg.cal ^ 32'h03c0_0000, state_reg.sel) ==
		fmatch(state_reg.alarm, state_reg.cal, state_reg.sel))
		else $error("month compared at select 4 or below");
	a_write_answer: assert property (do_write |=> state_reg.bus.bvalid)
		else $error("write not answered");
	a_read_answer: assert property (do_read |=> state_reg.bus.rvalid)
		else $error("read not answered");
	a_alarm_hold: assert property (state_reg.sync_cnt != 2'h1 && !swrst_req_seen
		|=> $stable(state_reg.alarm))
		else $error("alarm changed outside sync delay");
	a_guard_no_effect: assert property (do_write && peripheral_write_guard |=> $stable(state_reg.ctrl))
		else $error("guarded write changed control");
	a_flag_keep: assert property (do_write && !peripheral_write_guard && wr_idx == IDX_FLAGS &&
		!(axil_req.wstrb[1] && axil_req.wdata[FLG_ALARM]) && state_reg.flags[FLG_ALARM]
		|=> state_reg.flags[FLG_ALARM])
		else $error("alarm flag cleared by zero");

endmodule // cac_calendar_alarm

// file: cac_calendar_alarm_tb.sv
// Self-checking testbench for the calendar alarm block
`timescale 1ns/100ps
module cac_calendar_alarm_tb import cac_pkg::*; ;
	// Short prescale so a counter step is four clocks
	localparam int unsigned TICKS = 4;
	logic aclk;
	logic aresetn;
	logic guard;
	logic alarm_event;
	logic overflow_event;
	cac_axil_req_s req;
	cac_axil_rsp_s rsp;
	int num_errors;
	int checks_done;
	int cyc;
	int ev_cnt;
	int ov_cnt;
	logic [31:0] cal0;
	logic [31:0] rdv;
	logic [31:0] old;
	logic [31:0] nv;
	logic [1:0] resp;
	logic [3:0] st;
	logic [7:0] addrs [11] = '{8'h00, 8'h10, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h50, 8'h60, 8'h80, 8'h90};
	int lo [6] = '{0, 6, 12, 17, 22, 26};

	cac_calendar_alarm #(.TICK_CYCLES(TICKS)) u_cac_calendar_alarm (
		.aclk(aclk),
		.aresetn(aresetn),
		.axil_req(req),
		.axil_rsp(rsp),
		.peripheral_write_guard(guard),
		.alarm_event(alarm_event),
		.overflow_event(overflow_event)
	);

	initial aclk = 1'b0;
	always #50 aclk = ~aclk;

	always @(posedge aclk) begin
		if (alarm_event === 1'b1) ev_cnt <= ev_cnt + 1;
		if (overflow_event === 1'b1) ov_cnt <= ov_cnt + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			$display("FAIL run length expected below 20000 cycles seen 20000");
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Bready is raised with the request; legal, and it saves a cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic got;
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		got = 1'b0;
		do begin
			@(posedge aclk);
			if (rsp.awready === 1'b1) begin
				req.awvalid <= 1'b0;
				got = 1'b1;
			end
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
		chk("write address taken", {31'h0, got}, 32'h1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic got;
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		got = 1'b0;
		do begin
			@(posedge aclk);
			if (rsp.arready === 1'b1) begin
				req.arvalid <= 1'b0;
				got = 1'b1;
			end
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		chk("read address taken", {31'h0, got}, 32'h1);
	endtask

	function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		for (int b = 0; b < 4; b++) if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
		return o;
	endfunction

	// Lowers one field by one; every field of the start value is nonzero
	function automatic logic [31:0] bump(logic [31:0] v, int i);
		return v - (32'h1 << lo[i]);
	endfunction

	// One counting run: configure, count seven steps, stop, inspect
	task automatic run(input logic [2:0] s, input logic [31:0] a, input logic mc, input logic [1:0] md, input logic hit);
		int base;
		wr(8'h00, 32'h0, 4'h3, resp);
		wr(8'h30, 32'h100, 4'h3, resp);
		wr(8'h90, {29'h0, s}, 4'h1, resp);
		wr(8'h80, a, 4'hf, resp);
		wr(8'h60, cal0, 4'hf, resp);
		base = ev_cnt;
		wr(8'h00, {24'h0, mc, 3'h0, md, 2'h2}, 4'h3, resp);
		repeat (24) @(posedge aclk);
		wr(8'h00, 32'h0, 4'h3, resp);
		rd(8'h30, rdv, resp);
		chk("alarm flag", rdv, hit ? 32'h100 : 32'h0);
		rd(8'h60, rdv, resp);
		chk("calendar upper fields", {6'h0, rdv[31:6]}, (hit && mc) ? 32'h0 : {6'h0, cal0[31:6]});
		chk("alarm event seen", {31'h0, ev_cnt != base}, {31'h0, hit});
		if (hit) begin
			wr(8'h30, 32'h0, 4'h3, resp);
			rd(8'h30, rdv, resp);
			chk("flag after zero write", rdv, 32'h100);
			wr(8'h30, 32'h100, 4'h2, resp);
			rd(8'h30, rdv, resp);
			chk("flag after one write", rdv, 32'h0);
		end
		$display("test match sel %0d clear %0b mode %0d done", s, mc, md);
	endtask

	initial begin
		req = '0;
		guard = 1'b0;
		aresetn = 1'b0;
		num_errors = 0;
		checks_done = 0;
		cyc = 0;
		ev_cnt = 0;
		ov_cnt = 0;
		void'($urandom(32'hcab3));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (addrs[i]) begin
			rd(addrs[i], rdv, resp);
			chk("reset value", rdv, 32'h0);
			chk("read response", {30'h0, resp}, {30'h0, RESP_OKAY});
		end
		rd(8'h84, rdv, resp);
		chk("unmapped response", {30'h0, resp}, {30'h0, RESP_SLVERR});
		chk("unmapped data", rdv, 32'h0);
		$display("test reset map done");
		old = $urandom;
		wr(8'h80, old, 4'hf, resp);
		for (int k = 0; k < 8; k++) begin
			nv = $urandom;
			st = 4'($urandom);
			wr(8'h80, nv, st, resp);
			repeat (3) @(posedge aclk);
			old = merge(old, nv, st);
			rd(8'h80, rdv, resp);
			chk("alarm lanes", rdv, old);
		end
		nv = $urandom;
		wr(8'h50, nv, 4'h1, resp);
		rd(8'h50, rdv, resp);
		chk("byte register", rdv, {24'h0, nv[7:0]});
		$display("test byte lanes done");
		guard <= 1'b1;
		wr(8'h80, ~old, 4'hf, resp);
		chk("guarded response", {30'h0, resp}, {30'h0, RESP_SLVERR});
		guard <= 1'b0;
		repeat (3) @(posedge aclk);
		rd(8'h80, rdv, resp);
		chk("guarded alarm", rdv, old);
		$display("test write guard done");
		wr(8'h10, 32'h100, 4'h3, resp);
		for (int s = 0; s < 7; s++) begin
			cal0 = {6'(1 + $urandom % 60), 4'(1 + $urandom % 10), 5'(1 + $urandom % 25),
				5'(1 + $urandom % 20), 6'(1 + $urandom % 50), 6'(10 + $urandom % 20)};
			run(3'(s), (s < 6) ? bump(cal0, s) : cal0, 1'b1, 2'h2, 1'b1);
			if (s > 0) run(3'(s), bump(cal0, s - 1), 1'b1, 2'h2, 1'b0);
		end
		run(3'h6, cal0, 1'b0, 2'h2, 1'b1);
		run(3'h6, cal0, 1'b1, 2'h1, 1'b0);
		// Top of the calendar wraps to year 0, month 1, day 1
		wr(8'h10, 32'h8100, 4'h3, resp);
		wr(8'h60, {YEAR_MAX, MONTH_MAX, DAY_MAX, HOUR_MAX, MIN_MAX, SEC_MAX}, 4'hf, resp);
		wr(8'h00, 32'ha, 4'h1, resp);
		repeat (8) @(posedge aclk);
		wr(8'h00, 32'h0, 4'h1, resp);
		rd(8'h30, rdv, resp);
		chk("overflow flag", rdv, 32'h8000);
		rd(8'h60, rdv, resp);
		chk("wrapped calendar", {6'h0, rdv[31:6]}, {12'h000, 4'h1, 5'h01, 5'h00, 6'h00});
		chk("overflow event count", ov_cnt, 32'h1);
		$display("test year wrap done");
		wr(8'h00, 32'h1, 4'h1, resp);
		rd(8'h80, rdv, resp);
		chk("alarm after soft reset", rdv, 32'h0);
		rd(8'h60, rdv, resp);
		chk("calendar after soft reset", rdv, 32'h0);
		$display("test soft reset done");
		close_out();
	end
endmodule // cac_calendar_alarm_tb
